// >>> design/odd_gray_pulse_lut_mid.sv
// Purpose: write-only odd gray-level duration entries five to ten
// Assumes: host keeps mode restrictions; load word arrives synchronous
// Notes:   entries are never readable; only timing outputs show them
// Summary of operation
// RULE1 - an entry value N makes its gray level last N plus one periods.
// RULE2 - code 24h loads level ten, which resets to 27h.
// RULE3 - code 25h loads level nine, which resets to 1Ah.
// RULE4 - code 26h loads level eight, which resets to 12h.
// RULE5 - code 27h loads level seven, which resets to 0Ch.
// RULE6 - level six has an entry that resets to 08h.
// RULE7 - code 29h loads level five, which resets to 05h.
// RULE8 - the host sends no such load in 4-level, 64-level or mono mode.
// RULE9 - entries are write-only with no readback path.
// RULE10 - a load is a 16-bit word, code high byte, value low byte.

`timescale 1ns/100ps

module odd_gray_pulse_lut_mid
   import odd_lut_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        load_valid,
   input  wire logic [15:0] load_word,
   input  wire logic [2:0]  level_sel,
   input  wire logic        level_start,
   output logic             level_busy,
   output logic             level_done,
   output logic             load_hit
);
   import odd_lut_pkg::*;

   localparam logic [7:0] CODES [NUM_ENTRIES] = '{CMD_LVL5, CMD_LVL6,
      CMD_LVL7, CMD_LVL8, CMD_LVL9, CMD_LVL10};
   localparam logic [7:0] RSTS [NUM_ENTRIES] = '{RST_LVL5, RST_LVL6,
      RST_LVL7, RST_LVL8, RST_LVL9, RST_LVL10};

   load_word_t lw;
   assign lw.valid = load_valid;
   assign lw.code  = load_word[CMD_MSB:CMD_LSB];   // RULE10
   assign lw.value = load_word[DATA_MSB:DATA_LSB]; // RULE10

   // index 0 is level five, index 5 is level ten
   logic [7:0] entry_r   [NUM_ENTRIES];
   logic [7:0] entry_nxt [NUM_ENTRIES];
   logic [NUM_ENTRIES-1:0] match;
   logic hit_r, hit_nxt;

   genvar g;
   generate
      for (g = 0; g < NUM_ENTRIES; g++) begin : g_entry
         assign match[g] = lw.valid && (lw.code == CODES[g]);
         always_comb begin
            entry_nxt[g] = match[g] ? lw.value : entry_r[g]; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
         end
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               entry_r[g] <= RSTS[g]; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
            end else if (ce) begin
               entry_r[g] <= entry_nxt[g];
            end
         end
      end
   endgenerate

   always_comb begin
      hit_nxt = |match;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hit_r <= 1'b0;
      end else if (ce) begin
         hit_r <= hit_nxt;
      end
   end
   assign load_hit = hit_r;

   // entry value feeds the timer only; there is no read port
   logic [7:0] sel_duration;
   always_comb begin
      sel_duration = (level_sel < 3'(NUM_ENTRIES)) ? entry_r[level_sel]
                                                    : entry_r[0]; // RULE9
   end

   gray_period_timer u_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .start    (level_start),
      .duration (sel_duration), // RULE1
      .busy     (level_busy),
      .done     (level_done)
   );

   property p_lvl10;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL10)
         |=> entry_r[5] == $past(load_word[7:0]);
   endproperty
   a_lvl10: assert property (p_lvl10) else $error("level ten load"); // RULE2

   property p_lvl9;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL9)
         |=> entry_r[4] == $past(load_word[7:0]);
   endproperty
   a_lvl9: assert property (p_lvl9) else $error("level nine load"); // RULE3

   property p_lvl8;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL8)
         |=> entry_r[3] == $past(load_word[7:0]);
   endproperty
   a_lvl8: assert property (p_lvl8) else $error("level eight load"); // RULE4

   property p_lvl7;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL7)
         |=> entry_r[2] == $past(load_word[7:0]);
   endproperty
   a_lvl7: assert property (p_lvl7) else $error("level seven load"); // RULE5

   property p_lvl6_hold;
      @(posedge clk) disable iff (!rst_n)
      !(load_valid && load_word[15:8] == CMD_LVL6) |=> $stable(entry_r[1]);
   endproperty
   a_lvl6_hold: assert property (p_lvl6_hold) else $error("level six moved"); // RULE6

   property p_lvl6;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL6)
         |=> entry_r[1] == $past(load_word[7:0]);
   endproperty
   a_lvl6: assert property (p_lvl6) else $error("level six load"); // RULE6

   property p_lvl5;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_valid && load_word[15:8] == CMD_LVL5)
         |=> entry_r[0] == $past(load_word[7:0]);
   endproperty
   a_lvl5: assert property (p_lvl5) else $error("level five load"); // RULE7

   // codes 24h..29h form one contiguous block
   logic code_in_bank;
   assign code_in_bank = (load_word[CMD_MSB:CMD_LSB] >= CMD_LVL10)
                      && (load_word[CMD_MSB:CMD_LSB] <= CMD_LVL5);

   // a taken bank load raises load_hit for one cycle
   sequence s_bank_load;
      ce && load_valid && code_in_bank;
   endsequence

   property p_hit_set;
      @(posedge clk) disable iff (!rst_n)
      s_bank_load |=> load_hit;
   endproperty
   a_hit_set: assert property (p_hit_set) // RULE10
      else $error("bank load missed");

   property p_hit;
      @(posedge clk) disable iff (!rst_n)
      (ce && !(load_valid && code_in_bank)) |=> !load_hit;
   endproperty
   a_hit: assert property (p_hit) else $error("foreign code hit"); // RULE10

   property p_ce;
      @(posedge clk) disable iff (!rst_n)
      !ce |=> $stable(entry_r[0]) && $stable(entry_r[1])
         && $stable(entry_r[2]) && $stable(entry_r[3])
         && $stable(entry_r[4]) && $stable(entry_r[5])
         && $stable(load_hit) && $stable(level_busy);
   endproperty
   a_ce: assert property (p_ce) else $error("state moved with ce low"); // RULE9

   // defaults must show on the first edge after reset lets go
   property p_rst;
      @(posedge clk)
      $rose(rst_n) |-> entry_r[0] == RST_LVL5
         && entry_r[1] == RST_LVL6 && entry_r[2] == RST_LVL7
         && entry_r[3] == RST_LVL8 && entry_r[4] == RST_LVL9
         && entry_r[5] == RST_LVL10;
   endproperty
   a_rst: assert property (p_rst) // RULE2 RULE3 RULE4 RULE5 RULE6 RULE7
      else $error("entry default wrong");

   // timer seen from the pins and from u_timer.cnt_r
   sequence s_level_go;
      ce && level_start && !level_busy;
   endsequence

   property p_go;
      @(posedge clk) disable iff (!rst_n)
      s_level_go |=> level_busy && !level_done;
   endproperty
   a_go: assert property (p_go) else $error("level start lost"); // RULE1

   property p_sel;
      @(posedge clk) disable iff (!rst_n)
      (s_level_go ##0 (level_sel < 3'(NUM_ENTRIES)))
         |=> u_timer.cnt_r == $past(entry_r[level_sel]);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong entry timed"); // RULE1

   // unused selects fall back to level five
   property p_fallback;
      @(posedge clk) disable iff (!rst_n)
      (s_level_go ##0 (level_sel >= 3'(NUM_ENTRIES)))
         |=> u_timer.cnt_r == $past(entry_r[0]);
   endproperty
   a_fallback: assert property (p_fallback) // RULE1
      else $error("unused select not level five");

   property p_done_pulse;
      @(posedge clk) disable iff (!rst_n)
      (ce && level_done) |=> !level_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) // RULE1
      else $error("done longer than a cycle");

   property p_done_idle;
      @(posedge clk) disable iff (!rst_n)
      level_done |-> !level_busy;
   endproperty
   a_done_idle: assert property (p_done_idle) // RULE1
      else $error("done while busy");
endmodule : odd_gray_pulse_lut_mid

// >>> design/odd_lut_pkg.sv
// Purpose: constants and types for the odd gray-level duration bank
// Assumes: 16-bit load word, command code in the upper byte
// Notes:   entry for level six takes the code between seven and five

package odd_lut_pkg;
   localparam int         NUM_ENTRIES = 6;
   localparam int         CMD_MSB     = 15;
   localparam int         CMD_LSB     = 8;
   localparam int         DATA_MSB    = 7;
   localparam int         DATA_LSB    = 0;
   localparam logic [7:0] CMD_LVL10   = 8'h24;
   localparam logic [7:0] CMD_LVL9    = 8'h25;
   localparam logic [7:0] CMD_LVL8    = 8'h26;
   localparam logic [7:0] CMD_LVL7    = 8'h27;
   localparam logic [7:0] CMD_LVL6    = 8'h28;
   localparam logic [7:0] CMD_LVL5    = 8'h29;
   localparam logic [7:0] RST_LVL10   = 8'h27;
   localparam logic [7:0] RST_LVL9    = 8'h1A;
   localparam logic [7:0] RST_LVL8    = 8'h12;
   localparam logic [7:0] RST_LVL7    = 8'h0C;
   localparam logic [7:0] RST_LVL6    = 8'h08;
   localparam logic [7:0] RST_LVL5    = 8'h05;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [7:0] value;
   } load_word_t;

   typedef enum logic [2:0] {
      T_IDLE,
      T_RUN
   } timer_state_t;
endpackage : odd_lut_pkg

// >>> design/gray_period_timer.sv
// Purpose: times one gray level as entry value plus one clock periods
// Assumes: clk is the gray-step clock
// Notes:   start is ignored while a period is running

`timescale 1ns/100ps

module gray_period_timer
   import odd_lut_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       start,
   input  wire logic [7:0] duration,
   output logic            busy,
   output logic            done
);
   import odd_lut_pkg::*;

   timer_state_t st_r, st_nxt;
   logic [7:0]   cnt_r, cnt_nxt;
   logic         done_r, done_nxt;

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      case (st_r)
         T_IDLE: begin
            if (start) begin
               cnt_nxt = duration; // RULE1
               st_nxt  = T_RUN;
            end
         end
         T_RUN: begin
            if (cnt_r == 8'h00) begin
               st_nxt   = T_IDLE;
               done_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: st_nxt = T_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r   <= T_IDLE;
         cnt_r  <= 8'h00;
         done_r <= 1'b0;
      end else if (ce) begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = (st_r == T_RUN);
   assign done = done_r;

   // busy lasts exactly duration+1 enabled cycles
   logic [8:0] run_len_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_len_r <= 9'h000;
      end else if (ce) begin
         run_len_r <= busy ? run_len_r + 9'h001 : 9'h000;
      end
   end

   logic [7:0] duration_at_start_r;
   property p_len;
      @(posedge clk) disable iff (!rst_n)
      (ce && busy && cnt_r == 8'h00)
         |-> (run_len_r == 9'(duration_at_start_r));
   endproperty
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         duration_at_start_r <= 8'h00;
      end else if (ce && st_r == T_IDLE && start) begin
         duration_at_start_r <= duration;
      end
   end
   a_len: assert property (p_len) else $error("period length wrong"); // RULE1

   sequence s_started;
      ce && !busy && start;
   endsequence
   property p_start;
      @(posedge clk) disable iff (!rst_n)
      s_started |=> busy && cnt_r == $past(duration);
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // RULE1
endmodule : gray_period_timer

// >>> sim/host_load_model.sv
// Purpose: host side issuing 16-bit table loads
// Assumes: display stays in 16-level gray mode
// Notes:   call just after a clock edge; returns just after the next
`timescale 1ns/100ps
module host_load_model (
   input  wire logic        clk,
   output logic             load_valid,
   output logic [15:0]      load_word
);
   initial begin
      load_valid = 1'b0;
      load_word  = 16'h0000;
   end
   // never sent in 4-level, 64-level or mono mode
   task automatic send(input logic [7:0] code, input logic [7:0] val);
      load_valid = 1'b1;
      load_word  = {code, val};
      @(posedge clk);
      #10;
      load_valid = 1'b0;
      load_word  = ~{code, val};
   endtask : send
endmodule : host_load_model

// >>> sim/odd_gray_pulse_lut_mid_tb_top.sv
// Purpose: self-checking bench for the odd duration bank
// Assumes: entries seen only through the level timer
// Notes:   index 0..5 stands for levels 5..10
`timescale 1ns/100ps
module odd_gray_pulse_lut_mid_tb_top;
   import odd_lut_pkg::*;
   logic        clk, rst_n, ce, level_start, level_busy, level_done;
   logic        load_hit, load_valid;
   logic [15:0] load_word;
   logic [2:0]  level_sel;
   logic [7:0]  v;
   int          miscompares = 0;
   int          n_checks = 0;
   int          exp_q[6];
   logic [7:0]  codes[6] = '{CMD_LVL5, CMD_LVL6, CMD_LVL7,
                             CMD_LVL8, CMD_LVL9, CMD_LVL10};
   logic [7:0]  rst_v[6] = '{8'h05, 8'h08, 8'h0C, 8'h12, 8'h1A, 8'h27};

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   host_load_model i_host (.clk(clk), .load_valid(load_valid),
                           .load_word(load_word));
   odd_gray_pulse_lut_mid i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .load_valid(load_valid), .load_word(load_word),
      .level_sel(level_sel), .level_start(level_start),
      .level_busy(level_busy), .level_done(level_done),
      .load_hit(load_hit));

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
      n_checks++;
      if (exp !== got) begin
         miscompares++;
         $display("FAIL %s exp %0d got %0d", what, exp, got);
      end
   endtask : chk

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (6) @(posedge clk);
      #10;
      rst_n = 1'b1;
      foreach (exp_q[i]) exp_q[i] = rst_v[i];
   endtask : do_reset

   // busy lasts entry plus one enabled cycles, plus stall cycles of ce low
   task automatic time_level(int sel, int stall);
      int n;
      int idx;
      n = 0;
      idx = (sel < NUM_ENTRIES) ? sel : 0;
      level_sel   = sel[2:0];
      level_start = 1'b1;
      @(posedge clk);
      #10;
      level_start = 1'b0;
      while (level_busy === 1'b1 && n < 300) begin
         n++;
         ce = (n <= stall) ? 1'b0 : 1'b1;
         @(posedge clk);
         #10;
      end
      if (n >= 300) begin
         miscompares++;
         test_done();
      end
      chk("duration", 9'(exp_q[idx] + 1 + stall), 9'(n));
      chk("done", 9'h001, {8'h00, level_done});
   endtask : time_level

   // selects 6 and 7 time level five
   task automatic time_all(string name, int stall);
      for (int i = 0; i < 8; i++)
         time_level(i, stall);
      $display("test %s done", name);
   endtask : time_all

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      level_start = 1'b0;
      level_sel = 3'h0;
      void'($urandom(12155));
      do_reset();
      time_all("reset values", 0);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         i_host.send(codes[i], v);
         exp_q[i] = v;
         chk("load_hit", 9'h001, {8'h00, load_hit});
         @(posedge clk);
         #10;
      end
      time_all("loads", 2);
      i_host.send(8'h23, 8'h77);
      chk("load_hit", 9'h000, {8'h00, load_hit});
      @(posedge clk);
      #10;
      i_host.send(8'h2A, 8'h77);
      chk("load_hit", 9'h000, {8'h00, load_hit});
      time_all("foreign codes", 0);
      ce = 1'b0;
      i_host.send(CMD_LVL10, 8'(~exp_q[5]));
      ce = 1'b1;
      chk("load_hit", 9'h000, {8'h00, load_hit});
      time_level(5, 0);
      $display("test ce freeze done");
      do_reset();
      time_all("second reset", 1);
      test_done();
   end
endmodule : odd_gray_pulse_lut_mid_tb_top
